// [logic/bit_pattern_interpolation_buffer.sv]
/*
 * Bit pattern interpolation sequencer with an eight stage pre-buffer,
 * reached over an APB slave; drives per-axis plus and minus pulses.
 * Assumes a 100 MHz pclk, asynchronous active-low presetn, limit pins
 * from outside the clock domain and software limits from local logic.
 */
// Added by the designer: register access over APB and the register offsets.
// How it works
// - Commands 66h/67h/68h start two/three/four axes
// - Interp command pushes stage, starts unless held
// - Hold 77h stacks stages, release 78h drives
// - Plus and minus both set ends interpolation
// - Empty buffer ends after last stage
// - Eight stages of 16 bits per axis
// - Stack count shown in status bits 15:12
// - Count 0 empty, 8 full, no writes
// - Count drops by one per finished stage
// - Next-data flag set for counts 1 to 7
// - Stop on main axis flushes the buffer
// - Any limit on interpolating axis stops
// - Interrupt low on count 8->7 or 4->3
// - Interrupt cleared by command or drive end
// - Bits go out from D0 upward
// - Data low plus, high minus, 06h latches
// - Bit one pulses, bit zero stays quiet
`include "bpi_consts.svh"

module bit_pattern_interpolation_buffer
    import bpi_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int PATTERN_BITS = 16,
    parameter int AXES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] limit_plus_pin,
    input wire logic [3:0] limit_minus_pin,
    input wire logic [3:0] soft_limit,
    output logic [3:0] pulse_plus,
    output logic [3:0] pulse_minus,
    output logic drive_busy,
    output logic continuous_interp_irq_n
);

    if (DEPTH != 8 || PATTERN_BITS != 16 || AXES != 4) begin : g_check
        $error("Only eight stages of 16 bits for four axes are served");
    end

    core_t cur;
    core_t next;
    logic mem_we;
    stage_t mem_rdata;

    function automatic logic [4:0] reg_index(input logic [7:0] a);
        return a[6:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic [4:0] i;
        i = reg_index(a);
        return a[7] == 1'b0 && a[1:0] == 2'b00 &&
            (i == `IDX_COMMAND || i == `IDX_DATA_LOW ||
             i == `IDX_DATA_HIGH || i == `IDX_DIVIDER);
    endfunction

    // Lowest selected axis acts as the main axis
    function automatic logic [3:0] main_axis(input logic [3:0] m);
        return m & (~m + 4'h1);
    endfunction

    function automatic logic [2:0] axis_count(input logic [3:0] m);
        return 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
    endfunction

    function automatic logic [31:0] status_word(input core_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`ST_COUNT_LSB +: 4] = c.count;
        w[`ST_NEXT_BIT] = c.active && c.count >= 4'h1 &&
            c.count <= 4'h7;
        w[`ST_HOLD_BIT] = c.hold;
        w[`ST_BUSY_BIT] = c.st != IDLE;
        return w;
    endfunction

    stage_memory #(
        .WIDTH($bits(stage_t)),
        .DEPTH(DEPTH),
        .AW(3)
    ) u_stage_memory (
        .pclk(pclk),
        .we(mem_we),
        .waddr(cur.wr_ptr),
        .wdata(cur.staging),
        .raddr(cur.rd_ptr),
        .rdata(mem_rdata)
    );

    always_comb begin
        logic setup;
        logic access;
        logic [4:0] idx;
        logic [7:0] code;
        logic [3:0] axes;
        logic [3:0] plus_bits;
        logic [3:0] minus_bits;
        logic [3:0] limits;
        logic finish;
        logic flush;
        logic pop;
        logic [2:0] want;
        setup = 1'b0;
        access = 1'b0;
        idx = 5'h00;
        code = 8'h00;
        axes = 4'h0;
        plus_bits = 4'h0;
        minus_bits = 4'h0;
        limits = 4'h0;
        finish = 1'b0;
        flush = 1'b0;
        pop = 1'b0;
        want = 3'd0;
        mem_we = 1'b0;
        next = cur;
        next.pulse = '0;

        // Limit pins: three stages, a change counts once two agree
        next.lim_s1 = {limit_minus_pin, limit_plus_pin};
        next.lim_s2 = cur.lim_s1;
        next.lim_s3 = cur.lim_s2;
        if (cur.lim_s2 == cur.lim_s3) begin
            next.lim_q = cur.lim_s3;
        end

        // Either direction stops, so a limit area cannot be left
        limits = (cur.lim_q[3:0] | cur.lim_q[7:4] | soft_limit) &
            cur.axis_mask;

        unique case (cur.st)
            IDLE: begin
                if (cur.active && !cur.hold && cur.count != 4'h0) begin
                    next.st = FETCH;
                end
            end
            FETCH: begin
                next.current = mem_rdata;
                next.rd_ptr = cur.rd_ptr + 3'd1;
                next.bit_idx = 4'h0;
                next.tick = 16'h0000;
                next.st = RUN;
            end
            RUN: begin
                if (cur.tick >= cur.divider) begin
                    next.tick = 16'h0000;
                    for (int a = 0; a < 4; a++) begin
                        plus_bits[a] = cur.current[a].plus[cur.bit_idx];
                        minus_bits[a] = cur.current[a].minus[cur.bit_idx];
                    end
                    plus_bits = plus_bits & cur.axis_mask;
                    minus_bits = minus_bits & cur.axis_mask;
                    if ((plus_bits & minus_bits) != 4'h0) begin
                        finish = 1'b1;
                    end else begin
                        next.pulse.plus = plus_bits;
                        next.pulse.minus = minus_bits;
                        next.bit_idx = cur.bit_idx + 4'h1;
                        if (cur.bit_idx == 4'hf) begin
                            pop = 1'b1;
                            next.st = IDLE;
                            if (cur.count == 4'h1) begin
                                finish = 1'b1;
                            end
                        end
                    end
                end else begin
                    next.tick = cur.tick + 16'h0001;
                end
            end
        endcase

        if (cur.st != IDLE && limits != 4'h0) begin
            finish = 1'b1;
        end

        if (pop) begin
            next.count = cur.count - 4'h1;
        end

        // Ending discards whatever stages are still stacked
        if (finish) begin
            flush = 1'b1;
        end

        // APB slave: answer in the first access cycle
        setup = psel && !penable;
        access = psel && penable && cur.pready;
        idx = reg_index(paddr);
        next.pready = setup;
        next.pslverr = setup && !is_mapped(paddr);
        if (setup) begin
            if (!pwrite && is_mapped(paddr)) begin
                if (idx == `IDX_STATUS) begin
                    next.prdata = status_word(cur);
                end else if (idx == `IDX_DIVIDER) begin
                    next.prdata = {16'h0000, cur.divider};
                end else begin
                    next.prdata = 32'h0000_0000;
                end
            end else begin
                next.prdata = 32'h0000_0000;
            end
        end

        if (access && pwrite && !cur.pslverr) begin
            code = pwdata[7:0];
            axes = pwdata[`CMD_AXIS_LSB +: 4];
            if (idx == `IDX_DATA_LOW) begin
                next.data_low = pwdata[15:0];
            end else if (idx == `IDX_DATA_HIGH) begin
                next.data_high = pwdata[15:0];
            end else if (idx == `IDX_DIVIDER) begin
                next.divider = pwdata[15:0];
            end else begin
                unique case (code)
                    `CMD_SET_PATTERN: begin
                        for (int a = 0; a < 4; a++) begin
                            if (axes[a]) begin
                                next.staging[a].plus = cur.data_low;
                                next.staging[a].minus = cur.data_high;
                            end
                        end
                    end
                    `CMD_INTERP_MODE: begin
                        // At least two axes; mode is frozen while active
                        if (!cur.active &&
                            axis_count(cur.data_low[3:0]) >= 3'd2) begin
                            next.axis_mask = cur.data_low[3:0];
                        end
                    end
                    `CMD_BP_TWO, `CMD_BP_THREE, `CMD_BP_FOUR: begin
                        want = 3'(code - `CMD_BP_TWO) + 3'd2;
                        // Full buffer refuses the push silently
                        if (want == axis_count(cur.axis_mask) &&
                            next.count < 4'(DEPTH)) begin
                            mem_we = 1'b1;
                            next.wr_ptr = cur.wr_ptr + 3'd1;
                            next.count = next.count + 4'h1;
                            next.active = 1'b1;
                            next.irq_n = 1'b1;
                            flush = 1'b0;
                        end
                    end
                    `CMD_HOLD: begin
                        if ((axes & main_axis(cur.axis_mask)) != 4'h0) begin
                            next.hold = 1'b1;
                        end
                    end
                    `CMD_RELEASE: begin
                        if ((axes & main_axis(cur.axis_mask)) != 4'h0) begin
                            next.hold = 1'b0;
                        end
                    end
                    `CMD_STOP_INSTANT, `CMD_STOP_DECEL: begin
                        if ((axes & main_axis(cur.axis_mask)) != 4'h0) begin
                            flush = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (flush) begin
            next.count = 4'h0;
            next.rd_ptr = next.wr_ptr;
            next.active = 1'b0;
            next.st = IDLE;
            next.irq_n = 1'b1;
        end else if (finish && mem_we) begin
            // New stage arrived as the old run ended: keep only it
            next.count = 4'h1;
            next.rd_ptr = cur.wr_ptr;
            next.st = IDLE;
        end

        // Set wins over a clear in the same cycle
        if ((cur.count == `IRQ_HIGH_MARK &&
             next.count == `IRQ_HIGH_MARK - 4'h1) ||
            (cur.count == `IRQ_LOW_MARK &&
             next.count == `IRQ_LOW_MARK - 4'h1)) begin
            next.irq_n = 1'b0;
        end

        // Registered so the busy output leaves a flip-flop
        next.busy = next.st != IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.st <= IDLE;
            cur.axis_mask <= `MASK_RESET;
            cur.divider <= `DIVIDER_RESET;
            cur.irq_n <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign pulse_plus = cur.pulse.plus;
    assign pulse_minus = cur.pulse.minus;
    assign drive_busy = cur.busy;
    assign continuous_interp_irq_n = cur.irq_n;

endmodule

// [logic/bpi_consts.svh]
/*
 * Constants of the bit pattern interpolation block: register indices,
 * command codes, status bit positions and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BPI_CONSTS_SVH
`define BPI_CONSTS_SVH

// Register indices; the byte address is four times the index
`define IDX_COMMAND 5'h00
`define IDX_STATUS 5'h00
`define IDX_DATA_LOW 5'h06
`define IDX_DATA_HIGH 5'h07
`define IDX_DIVIDER 5'h08

// Command codes in the low byte of the command register
`define CMD_SET_PATTERN 8'h06
`define CMD_INTERP_MODE 8'h2a
`define CMD_BP_TWO 8'h66
`define CMD_BP_THREE 8'h67
`define CMD_BP_FOUR 8'h68
`define CMD_HOLD 8'h77
`define CMD_RELEASE 8'h78
`define CMD_STOP_INSTANT 8'h27
`define CMD_STOP_DECEL 8'h26

// Field positions
`define CMD_AXIS_LSB 8
`define ST_COUNT_LSB 12
`define ST_NEXT_BIT 11
`define ST_HOLD_BIT 1
`define ST_BUSY_BIT 0

// Reset values and counter marks
`define DIVIDER_RESET 16'h0063
`define MASK_RESET 4'h3
`define IRQ_HIGH_MARK 4'h8
`define IRQ_LOW_MARK 4'h4

`endif

// [logic/bpi_pkg.sv]
/*
 * Types of the bit pattern interpolation block.
 * Assumes bpi_consts.svh holds the numeric constants.
 */
package bpi_pkg;

    typedef struct packed {
        logic [15:0] minus;
        logic [15:0] plus;
    } axis_pattern_t;

    typedef axis_pattern_t [3:0] stage_t;

    typedef struct packed {
        logic [3:0] minus;
        logic [3:0] plus;
    } drive_pulse_t;

    typedef enum logic [1:0] {IDLE, FETCH, RUN} seq_state_t;

    typedef struct packed {
        seq_state_t st;
        logic [3:0] axis_mask;
        logic [15:0] data_low;
        logic [15:0] data_high;
        stage_t staging;
        stage_t current;
        logic [2:0] wr_ptr;
        logic [2:0] rd_ptr;
        logic [3:0] count;
        logic active;
        logic busy;
        logic hold;
        logic [3:0] bit_idx;
        logic [15:0] divider;
        logic [15:0] tick;
        drive_pulse_t pulse;
        logic irq_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] lim_s1;
        logic [7:0] lim_s2;
        logic [7:0] lim_s3;
        logic [7:0] lim_q;
    } core_t;

endpackage

// [logic/stage_memory.sv]
/*
 * Stage memory of the pre-buffer: one write port, one read port whose
 * data leave a register one cycle after the address.
 * Assumes a single clock and no reset on the storage.
 */
module stage_memory #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// [verification/bpi_checker.sv]
/* Port checker of the pattern buffer block.
   Bound to its top module; one clock, async low reset. */
`include "bpi_consts.svh"

module bpi_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] limit_plus_pin,
    input wire logic [3:0] limit_minus_pin,
    input wire logic [3:0] soft_limit,
    input wire logic [3:0] pulse_plus,
    input wire logic [3:0] pulse_minus,
    input wire logic drive_busy,
    input wire logic continuous_interp_irq_n
);
    logic held;
    wire logic rd_st = pready && !pwrite && paddr == 8'h00 && !pslverr;
    wire logic wr_cmd = psel && penable && pready && pwrite && paddr == 8'h00;
    wire logic [7:0] code = pwdata[7:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only hold aimed at the main axis X counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            held <= 1'b0;
        else if (wr_cmd && pwdata[8] && code == `CMD_HOLD)
            held <= 1'b1;
        else if (wr_cmd && pwdata[8] && code == `CMD_RELEASE)
            held <= 1'b0;
    end
    property p_flag;
        rd_st |-> !prdata[11] || prdata[15:12] inside {[1:7]};
    endproperty
    a_flag: assert property (p_flag)
        else $error("next flag set with bad count");
    property p_max; rd_st |-> prdata[15:12] <= 4'h8; endproperty
    a_max: assert property (p_max)
        else $error("stack count above full");
    property p_both; (pulse_plus & pulse_minus) == 4'h0; endproperty
    a_both: assert property (p_both)
        else $error("pulse in both directions");
    property p_pulse;
        |{pulse_plus, pulse_minus} |-> $past(drive_busy);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulse while idle");
    property p_limit; |soft_limit[1:0] && drive_busy |=> ##[0:2] !drive_busy;
    endproperty
    a_limit: assert property (p_limit)
        else $error("limit did not stop");
    property p_stop; wr_cmd && pwdata[8] &&
        (code == `CMD_STOP_INSTANT || code == `CMD_STOP_DECEL)
        |=> ##[0:2] !drive_busy; endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not halt");
    property p_hold; held && !drive_busy |=> !drive_busy; endproperty
    a_hold: assert property (p_hold)
        else $error("drive started while held");
    property p_irq;
        $fell(continuous_interp_irq_n) |-> $past(drive_busy);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without stage pop");
    c_irq: cover property ($fell(continuous_interp_irq_n));
    c_rel: cover property (wr_cmd && code == `CMD_RELEASE);
    c_run: cover property (drive_busy [*8]);
endmodule

// [verification/host_model.sv]
/* Host processor model: APB master writing commands and patterns.
   Assumes the bench calls its tasks through the instance. */
module host_model (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, {16'h0000, d}, q, e);
    endtask
    // Both patterns first, then the latch command
    task load(input int ax, input logic [15:0] p, input logic [15:0] m);
        wr(8'h18, p);
        wr(8'h1c, m);
        wr(8'h00, 16'h0006 | (16'h0100 << ax));
    endtask
    // Wait for room so a full buffer never sees a push
    task push_when_room(input logic [7:0] c);
        logic [31:0] q;
        logic e;
        do xfer(1'b0, 8'h00, 32'h0, q, e); while (q[11] !== 1'b1);
        wr(8'h00, {8'h00, c});
    endtask
endmodule

// [verification/bit_pattern_interpolation_buffer_bench.sv]
/* Bench of the pattern buffer block, host model as APB master.
   Assumes the checker is bound below; pclk 100 MHz. */
module bit_pattern_interpolation_buffer_bench import bpi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] limit_plus_pin = 0, limit_minus_pin = 0, soft_limit = 0;
    logic [3:0] pulse_plus, pulse_minus;
    logic drive_busy, continuous_interp_irq_n;
    int bad_count = 0, compares = 0;
    drive_pulse_t got[$], exp[$];
    logic [15:0] ap[4] = '{16'h5a3c, 16'h00f1, 16'h8001, 16'hf00f};
    logic [15:0] am[4] = '{16'ha5c3, 16'h0e00, 16'h0240, 16'h0ff0};
    bit_pattern_interpolation_buffer dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .limit_plus_pin(limit_plus_pin), .limit_minus_pin(limit_minus_pin),
        .soft_limit(soft_limit), .pulse_plus(pulse_plus),
        .pulse_minus(pulse_minus), .drive_busy(drive_busy),
        .continuous_interp_irq_n(continuous_interp_irq_n));
    host_model host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk)
        if ((pulse_plus | pulse_minus) != 4'h0)
            got.push_back({pulse_minus, pulse_plus});
    task check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, want);
        end
    endtask
    task st(output logic [31:0] q);
        logic e;
        host.xfer(1'b0, 8'h00, 32'h0, q, e);
    endtask
    task push(input int n);
        for (int a = 0; a < n; a++) host.load(a, ap[a], am[a]);
        host.wr(8'h00, 16'(8'h64 + n));
    endtask
    task exp_stage(input int n);
        drive_pulse_t v;
        for (int b = 0; b < 16; b++) begin
            v = '0;
            for (int a = 0; a < n; a++) begin
                v.plus[a] = ap[a][b];
                v.minus[a] = am[a][b];
            end
            if (v != '0) exp.push_back(v);
        end
    endtask
    // Idle gaps between stages last one cycle, so wait for four
    task wait_idle;
        int q;
        q = 0;
        while (q < 4) begin
            @(posedge pclk);
            q = (drive_busy === 1'b1) ? 0 : q + 1;
        end
    endtask
    task cmp_stream;
        check(32'(got.size()), 32'(exp.size()));
        foreach (exp[i])
            if (i < got.size()) check(32'(got[i]), 32'(exp[i]));
        got = {};
        exp = {};
    endtask
    task wait_irq;
        while (continuous_interp_irq_n !== 1'b0) @(posedge pclk);
    endtask
    task t_reset;
        logic [31:0] q;
        logic e;
        st(q);
        check(q, 32'h0);
        host.xfer(1'b0, 8'h24, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        host.xfer(1'b0, 8'h20, 32'h0, q, e);
        check(q, 32'h63);
        host.wr(8'h20, 16'h0000);
        $display("test reset done");
    endtask
    task t_two;
        logic [31:0] q;
        repeat (2) begin
            push(2);
            exp_stage(2);
        end
        wait_idle;
        cmp_stream;
        st(q);
        check(q, 32'h0);
        check({31'h0, continuous_interp_irq_n}, 32'h1);
        $display("test two axes done");
    endtask
    task t_fill;
        logic [31:0] q;
        host.wr(8'h00, 16'h0177);
        repeat (8) begin
            push(2);
            exp_stage(2);
        end
        st(q);
        check(q[15:11], 32'h10);
        push(2);
        st(q);
        check(q[15:11], 32'h10);
        host.wr(8'h00, 16'h0178);
        wait_irq;
        st(q);
        check(q[15:11], 32'h0f);
        for (int a = 0; a < 2; a++) host.load(a, ap[a], am[a]);
        host.push_when_room(8'h66);
        exp_stage(2);
        #1;
        check({31'h0, continuous_interp_irq_n}, 32'h1);
        wait_idle;
        cmp_stream;
        check({31'h0, continuous_interp_irq_n}, 32'h1);
        $display("test fill done");
    endtask
    task t_end;
        logic [31:0] q;
        host.wr(8'h00, 16'h0177);
        host.load(0, 16'h003f, 16'h0020);
        host.load(1, 16'h0000, 16'h0000);
        host.wr(8'h00, 16'h0066);
        push(2);
        host.wr(8'h00, 16'h0178);
        wait_idle;
        repeat (5) exp.push_back(8'h01);
        cmp_stream;
        st(q);
        check(q, 32'h0);
        $display("test end code done");
    endtask
    task t_stop;
        logic [31:0] q;
        for (int k = 0; k < 2; k++) begin
            host.wr(8'h00, 16'h0177);
            repeat (4) push(2);
            host.wr(8'h00, 16'h0178);
            wait_irq;
            host.wr(8'h00, k ? 16'h0126 : 16'h0127);
            wait_idle;
            st(q);
            check(q, 32'h0);
            check({31'h0, continuous_interp_irq_n}, 32'h1);
            got = {};
        end
        $display("test stop done");
    endtask
    task t_limit;
        logic [31:0] q;
        for (int k = 0; k < 3; k++) begin
            push(2);
            repeat (4) @(posedge pclk);
            {limit_plus_pin, limit_minus_pin, soft_limit} <=
                12'h2 << (4 * k);
            wait_idle;
            st(q);
            check(q, 32'h0);
            check(32'(got.size() < 16), 32'h1);
            {limit_plus_pin, limit_minus_pin, soft_limit} <= 12'h0;
            repeat (8) @(posedge pclk);
            got = {};
        end
        $display("test limit done");
    endtask
    task t_modes;
        logic [31:0] q;
        for (int n = 3; n < 5; n++) begin
            host.wr(8'h18, n == 3 ? 16'h0007 : 16'h000f);
            host.wr(8'h00, 16'h002a);
            push(n);
            exp_stage(n);
            wait_idle;
            cmp_stream;
        end
        host.wr(8'h18, 16'h0003);
        host.wr(8'h00, 16'h002a);
        push(3);
        st(q);
        check(q, 32'h0);
        $display("test modes done");
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_two;
        t_fill;
        t_end;
        t_stop;
        t_limit;
        t_modes;
        report_and_stop;
    end
    initial begin
        #400000;
        bad_count++;
        report_and_stop;
    end
endmodule

bind bit_pattern_interpolation_buffer bpi_checker chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .limit_plus_pin(limit_plus_pin),
    .limit_minus_pin(limit_minus_pin), .soft_limit(soft_limit),
    .pulse_plus(pulse_plus), .pulse_minus(pulse_minus),
    .drive_busy(drive_busy),
    .continuous_interp_irq_n(continuous_interp_irq_n));
